// *** ldf_map.svh ***
`ifndef LDF_MAP_SVH
`define LDF_MAP_SVH

// register byte addresses
`define LDF_OFS_CFG      32'h0000_A0B0
`define LDF_OFS_TO_HIGH  32'h0000_A0B4
`define LDF_OFS_TO_LOW   32'h0000_A0B8
`define LDF_OFS_CTL      32'h0000_A0BC

// timeout configuration fields
`define LDF_CFG_TX_EN    0
`define LDF_CFG_RX_EN    1
`define LDF_CFG_TX_FLAG  2
`define LDF_CFG_RX_FLAG  3
`define LDF_CFG_TX_WAKE  4
`define LDF_CFG_RX_WAKE  5
`define LDF_CFG_AUTOEXIT 6
`define LDF_CFG_LIM_LSB  7
`define LDF_CFG_RW_MASK  8'hF3
`define LDF_CFG_FL_MASK  8'h0C

// control register fields
`define LDF_CTL_GIE      0

// reset values and counter constants
`define LDF_CFG_RST      8'h00
`define LDF_BYTE_RST     8'h00
`define LDF_WORD_RST     32'h0000_0000
`define LDF_LIM_RST      17'h0_0000
`define LDF_LIM_ONE      17'h0_0001
`define LDF_LIM_MAX      17'h1_FFFF

`endif

// *** ldf_pkg.sv ***
package ldf_pkg;
    typedef logic [31:0] ldf_word_t;
    typedef logic [16:0] ldf_limit_t;
    typedef logic [1:0]  ldf_trans_t;
    typedef logic [2:0]  ldf_size_t;
    typedef enum logic [0:0] {
        LDF_CH_TX = 1'b0,
        LDF_CH_RX = 1'b1
    } ldf_ch_t;
endpackage

// *** ldf_tmr_if.sv ***
`timescale 1ns/10ps
interface ldf_tmr_if;
    logic              dom;
    ldf_pkg::ldf_limit_t limit;
    logic              fault;
    modport tmr (input dom, input limit, output fault);
    modport ctl (output dom, output limit, input fault);
endinterface

// *** ldf_dom_timer.sv ***
`timescale 1ns/10ps
`include "ldf_map.svh"
module ldf_dom_timer (
    input  wire logic i_clk,
    input  wire logic i_nrst,
    ldf_tmr_if.tmr    tmr
);
    import ldf_pkg::*;

    ldf_limit_t cnt_reg;
    ldf_limit_t cnt_next;
    logic       fault_reg;
    logic       fault_next;

    // saturating compare: lowering the limit mid-fault cannot wrap the count
    wire        at_limit = (cnt_reg >= tmr.limit);
    wire [16:0] cnt_inc  = 17'(cnt_reg + `LDF_LIM_ONE);

    // a zero limit always counts as reached (at_limit), so it disables
    assign cnt_next   = !tmr.dom ? `LDF_LIM_RST :
                        at_limit ? cnt_reg : cnt_inc;
    assign fault_next = tmr.dom & !at_limit & (cnt_inc == tmr.limit);
    assign tmr.fault  = fault_reg;

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            cnt_reg   <= `LDF_LIM_RST;
            fault_reg <= 1'b0;
        end else begin
            cnt_reg   <= cnt_next;
            fault_reg <= fault_next;
        end
    end
endmodule

// *** ldf_top.sv ***
// Functional notes
// - rx timeout limit: 17 bits, config bit 7 lowest, byte registers above
// - auto exit set: rx fault leaves break state; other exits unaffected
// - rx fault flag set by hardware, held until software clears it
// - tx fault flag set by hardware, held, only a software write clears it
// - tx and rx fault interrupt enables sit in config bits 0 and 1
`timescale 1ns/10ps
`include "ldf_map.svh"
module ldf_top (
    input  wire logic                i_clk,
    input  wire logic                i_nrst,
    input  wire logic                i_hsel,
    input  wire ldf_pkg::ldf_word_t  i_haddr,
    input  wire ldf_pkg::ldf_trans_t i_htrans,
    input  wire logic                i_hwrite,
    input  wire ldf_pkg::ldf_size_t  i_hsize,
    input  wire logic                i_hready,
    input  wire ldf_pkg::ldf_word_t  i_hwdata,
    output logic [31:0]              o_hrdata,
    output logic                     o_hreadyout,
    output logic                     o_hresp,
    input  wire logic                i_rxd,
    input  wire logic                i_txd,
    input  wire logic                i_brk_state,
    output logic                     o_brk_exit,
    output logic                     o_irq
);
    import ldf_pkg::*;

    logic [7:0] cfg_reg;
    logic [7:0] cfg_next;
    logic [7:0] to_high_reg;
    logic [7:0] to_low_reg;
    logic       gie_reg;
    logic       dp_wr_reg;
    ldf_word_t  dp_addr_reg;
    ldf_word_t  hrdata_reg;
    logic       hready_reg;
    logic       hresp_reg;
    logic       irq_reg;
    logic       irq_next;
    logic       brk_exit_reg;
    logic       brk_exit_next;
    ldf_limit_t limit;
    logic [1:0] fault_pulse;

    // bus decode; hsize is ignored since only whole words are carried
    wire addr_ok  = i_hsel & i_hready & i_htrans[1];
    wire wr_cfg   = dp_wr_reg & (dp_addr_reg == `LDF_OFS_CFG);
    wire wr_high  = dp_wr_reg & (dp_addr_reg == `LDF_OFS_TO_HIGH);
    wire wr_low   = dp_wr_reg & (dp_addr_reg == `LDF_OFS_TO_LOW);
    wire wr_ctl   = dp_wr_reg & (dp_addr_reg == `LDF_OFS_CTL);
    wire sel_cfg  = (i_haddr == `LDF_OFS_CFG);
    wire sel_high = (i_haddr == `LDF_OFS_TO_HIGH);
    wire sel_low  = (i_haddr == `LDF_OFS_TO_LOW);
    wire sel_ctl  = (i_haddr == `LDF_OFS_CTL);

    // unmapped addresses read as zero
    wire [31:0] rd_data = sel_cfg  ? {24'h00_0000, cfg_reg}     :
                          sel_high ? {24'h00_0000, to_high_reg} :
                          sel_low  ? {24'h00_0000, to_low_reg}  :
                          sel_ctl  ? {31'h0000_0000, gie_reg}   :
                          `LDF_WORD_RST;

    assign limit = {to_high_reg, to_low_reg,
                    cfg_reg[`LDF_CFG_LIM_LSB]};

    // fault flags: write one clears, a fault in the same cycle wins
    wire [7:0] fl_set = {4'h0, fault_pulse[LDF_CH_RX],
                         fault_pulse[LDF_CH_TX], 2'b00};
    wire [7:0] fl_clr = wr_cfg ? (i_hwdata[7:0] & `LDF_CFG_FL_MASK)
                               : 8'h00;
    // wake enables are only stored; no wake logic lives in this block
    wire [7:0] cfg_rw = wr_cfg ? (i_hwdata[7:0] & `LDF_CFG_RW_MASK)
                               : (cfg_reg & `LDF_CFG_RW_MASK);
    assign cfg_next = cfg_rw | (((cfg_reg & `LDF_CFG_FL_MASK) & ~fl_clr)
                      | fl_set);
    wire [1:0] flags_next = {cfg_next[`LDF_CFG_RX_FLAG],
                             cfg_next[`LDF_CFG_TX_FLAG]};
    wire [1:0] ens_next   = {cfg_next[`LDF_CFG_RX_EN],
                             cfg_next[`LDF_CFG_TX_EN]};
    wire       gie_next   = wr_ctl ? i_hwdata[`LDF_CTL_GIE] : gie_reg;
    assign irq_next = gie_next & |(flags_next & ens_next);
    // break exit only while break state is live, and only when enabled
    assign brk_exit_next = fault_pulse[LDF_CH_RX] & i_brk_state
                           & cfg_reg[`LDF_CFG_AUTOEXIT];

    wire [1:0] dom_line = {~i_rxd, ~i_txd};

    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : g_ch
            ldf_tmr_if tif ();
            assign tif.dom        = dom_line[g];
            assign tif.limit      = limit;
            assign fault_pulse[g] = tif.fault;
            ldf_dom_timer u_tmr (
                .i_clk  (i_clk),
                .i_nrst (i_nrst),
                .tmr    (tif)
            );
        end
    endgenerate

    // zero wait states and always OKAY: the slave never stretches a transfer
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            dp_wr_reg   <= 1'b0;
            dp_addr_reg <= `LDF_WORD_RST;
            hrdata_reg  <= `LDF_WORD_RST;
            hready_reg  <= 1'b1;
            hresp_reg   <= 1'b0;
        end else begin
            dp_wr_reg   <= addr_ok & i_hwrite;
            dp_addr_reg <= addr_ok ? i_haddr : dp_addr_reg;
            hrdata_reg  <= (addr_ok & !i_hwrite) ? rd_data : hrdata_reg;
            hready_reg  <= 1'b1;
            hresp_reg   <= 1'b0;
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            cfg_reg      <= `LDF_CFG_RST;
            to_high_reg  <= `LDF_BYTE_RST;
            to_low_reg   <= `LDF_BYTE_RST;
            gie_reg      <= 1'b0;
            irq_reg      <= 1'b0;
            brk_exit_reg <= 1'b0;
        end else begin
            cfg_reg      <= cfg_next;
            to_high_reg  <= wr_high ? i_hwdata[7:0] : to_high_reg;
            to_low_reg   <= wr_low ? i_hwdata[7:0] : to_low_reg;
            gie_reg      <= gie_next;
            irq_reg      <= irq_next;
            brk_exit_reg <= brk_exit_next;
        end
    end

    assign o_hrdata    = hrdata_reg;
    assign o_hreadyout = hready_reg;
    assign o_hresp     = hresp_reg;
    assign o_irq       = irq_reg;
    assign o_brk_exit  = brk_exit_reg;

    // helpers: current dominant run length per line, saturating;
    // counted apart from the timers so the checks do not trust their counts
    ldf_limit_t rx_run_reg;
    ldf_limit_t tx_run_reg;
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            rx_run_reg <= `LDF_LIM_RST;
            tx_run_reg <= `LDF_LIM_RST;
        end else begin
            rx_run_reg <= i_rxd ? `LDF_LIM_RST :
                          (rx_run_reg == `LDF_LIM_MAX) ? rx_run_reg :
                          17'(rx_run_reg + `LDF_LIM_ONE);
            tx_run_reg <= i_txd ? `LDF_LIM_RST :
                          (tx_run_reg == `LDF_LIM_MAX) ? tx_run_reg :
                          17'(tx_run_reg + `LDF_LIM_ONE);
        end
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_nrst);

    // the line may already be released when the pulse shows, so look back
    a_rx_limit_match: assert property (
        fault_pulse[LDF_CH_RX] |-> (rx_run_reg == limit) && $past(!i_rxd))
        else $error("rx fault not at the assembled 17-bit limit");

    a_tx_limit_match: assert property (
        fault_pulse[LDF_CH_TX] |-> (tx_run_reg == limit) && $past(!i_txd))
        else $error("tx fault not at the shared timeout limit");

    a_zero_limit_off: assert property (
        limit == `LDF_LIM_RST |=> fault_pulse == 2'b00)
        else $error("fault raised while the timeout limit is zero");

    a_brk_auto_exit: assert property (
        o_brk_exit |-> $past(cfg_reg[`LDF_CFG_AUTOEXIT])
                    && $past(fault_pulse[LDF_CH_RX]) && $past(i_brk_state))
        else $error("break exit without enabled rx fault");

    a_rx_flag_sticky: assert property (
        (fault_pulse[LDF_CH_RX] ||
         (cfg_reg[`LDF_CFG_RX_FLAG] && !(wr_cfg && i_hwdata[3])))
        |=> cfg_reg[`LDF_CFG_RX_FLAG])
        else $error("rx fault flag lost without software clear");

    a_tx_flag_hold: assert property (
        $fell(cfg_reg[`LDF_CFG_TX_FLAG]) |->
            $past(wr_cfg) && $past(i_hwdata[2]) && !$past(fault_pulse[0]))
        else $error("tx fault flag cleared without software write");

    a_enable_bits: assert property (
        wr_cfg |=> cfg_reg[1:0] == $past(i_hwdata[1:0]))
        else $error("interrupt enables not written from config bits 1:0");

    a_irq_gating: assert property (
        o_irq == (gie_reg && |({cfg_reg[3], cfg_reg[2]} &
                               {cfg_reg[1], cfg_reg[0]})))
        else $error("interrupt output disagrees with flags and enables");

    a_exit_one_pulse: assert property (
        o_brk_exit |=> !o_brk_exit)
        else $error("break exit request longer than one cycle");

    a_tx_flag_set: assert property (
        fault_pulse[LDF_CH_TX] |=> cfg_reg[`LDF_CFG_TX_FLAG])
        else $error("tx fault did not set its flag");

    a_gie_off_quiet: assert property (
        !gie_reg |-> !o_irq)
        else $error("interrupt raised with global enable off");

    c_no_autoexit: cover property (
        fault_pulse[LDF_CH_RX] && !cfg_reg[`LDF_CFG_AUTOEXIT]);
    c_rx_fault:  cover property (fault_pulse[LDF_CH_RX]);
    c_tx_fault:  cover property (fault_pulse[LDF_CH_TX]);
    c_brk_exit:  cover property (o_brk_exit);
    c_irq_clear: cover property (o_irq ##[1:20] !o_irq);
endmodule

// *** ldf_lin_model.sv ***
`timescale 1ns/10ps
module ldf_lin_model (
    input  wire logic i_clk,
    output logic      o_rxd,
    output logic      o_txd
);
    // idle lines are recessive: the bus pull-up holds them high
    initial begin
        o_rxd = 1'b1;
        o_txd = 1'b1;
    end
    // hold one line dominant for n sampling edges, then release it
    task automatic dominant(input bit ch, input int n);
        @(posedge i_clk);
        if (ch) o_rxd <= 1'b0;
        else o_txd <= 1'b0;
        repeat (n) @(posedge i_clk);
        o_rxd <= 1'b1;
        o_txd <= 1'b1;
    endtask
endmodule

// *** test_lin_dominant_fault_timeout.sv ***
`timescale 1ns/10ps
`include "ldf_map.svh"
module test_lin_dominant_fault_timeout;
    import ldf_pkg::*;
    logic       i_clk, i_nrst, i_hsel, i_hwrite, i_brk_state, rxd, txd;
    ldf_word_t  i_haddr, i_hwdata, rd;
    ldf_trans_t i_htrans;
    logic [31:0] o_hrdata;
    logic       o_hreadyout, o_hresp, o_brk_exit, o_irq;
    logic [6:0] wk;
    int         errors = 0, tests_run = 0, exits = 0, seed = 72, lim;
    ldf_word_t  regs [5] = '{`LDF_OFS_CFG, `LDF_OFS_TO_HIGH,
                             `LDF_OFS_TO_LOW, `LDF_OFS_CTL, 32'h0000_A0C0};

    ldf_top u_dut (.i_clk(i_clk), .i_nrst(i_nrst), .i_hsel(i_hsel),
        .i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite),
        .i_hsize(3'b010), .i_hready(o_hreadyout), .i_hwdata(i_hwdata),
        .o_hrdata(o_hrdata), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp),
        .i_rxd(rxd), .i_txd(txd), .i_brk_state(i_brk_state),
        .o_brk_exit(o_brk_exit), .o_irq(o_irq));
    ldf_lin_model u_line (.i_clk(i_clk), .o_rxd(rxd), .o_txd(txd));

    initial begin
        i_clk = 1'b0;
        forever #20 i_clk = ~i_clk;
    end
    always @(posedge i_clk) if (o_brk_exit === 1'b1) exits <= exits + 1;

    function automatic ldf_word_t cfg_exp(int l, logic [6:0] c);
        return {24'h00_0000, l[0], c};
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic finish_test;
        $display("errors=%0d tests_run=%0d", errors, tests_run);
        if (errors == 0 && tests_run > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic wait_ready;
        int n;
        n = 0;
        do begin
            @(posedge i_clk);
            n++;
        end while (o_hreadyout !== 1'b1 && n < 50);
        if (n >= 50) begin
            errors++;
            finish_test();
        end
    endtask
    task automatic bus(input bit wr, input ldf_word_t a, input ldf_word_t d);
        i_hsel <= 1'b1;
        i_htrans <= 2'b10;
        i_haddr <= a;
        i_hwrite <= wr;
        wait_ready();
        i_htrans <= 2'b00;
        i_hwdata <= d;
        wait_ready();
        rd = o_hrdata;
    endtask
    task automatic rdchk(input ldf_word_t a, input ldf_word_t exp);
        bus(1'b0, a, 32'h0000_0000);
        check(rd, exp);
    endtask
    // o_irq updates at the write's closing edge, so look one edge later
    task automatic irqchk(input logic exp);
        @(posedge i_clk);
        check({31'h0, o_irq}, {31'h0, exp});
    endtask
    task automatic setup(input int l, input logic [6:0] c);
        bus(1'b1, `LDF_OFS_CFG, cfg_exp(l, c));
        bus(1'b1, `LDF_OFS_TO_LOW, {24'h00_0000, l[8:1]});
        bus(1'b1, `LDF_OFS_TO_HIGH, {24'h00_0000, l[16:9]});
    endtask
    task automatic fault(input bit ch, input int n, input logic [6:0] c,
                         input logic irq, input int ex);
        int e0;
        e0 = exits;
        u_line.dominant(ch, n);
        repeat (3) @(posedge i_clk);
        rdchk(`LDF_OFS_CFG, cfg_exp(lim, c));
        check({31'h0, o_irq}, {31'h0, irq});
        check(exits - e0, ex);
    endtask

    initial begin
        {i_nrst, i_hsel, i_hwrite, i_brk_state} = 4'h0;
        {i_haddr, i_hwdata, i_htrans} = '0;
        repeat (8) @(posedge i_clk);
        i_nrst <= 1'b1;
        bus(1'b1, regs[4], $random(seed));
        foreach (regs[i]) rdchk(regs[i], `LDF_WORD_RST);
        // zero limit: a long dominant run must not raise a fault
        fault(1'b1, 12, 7'h00, 1'b0, 0);
        i_brk_state <= 1'b1;
        bus(1'b1, `LDF_OFS_CTL, 32'h0000_0001);
        repeat (4) begin
            lim = 3 + ($random(seed) & 7);
            wk = 7'($random(seed)) & 7'h30;
            setup(lim, 7'h43 | wk);
            fault(1'b1, lim - 1, 7'h43 | wk, 1'b0, 0);
            fault(1'b1, lim, 7'h4B | wk, 1'b1, 1);
            bus(1'b1, `LDF_OFS_CFG, cfg_exp(lim, 7'h43 | wk));
            rdchk(`LDF_OFS_CFG, cfg_exp(lim, 7'h4B | wk));
            bus(1'b1, `LDF_OFS_CFG, cfg_exp(lim, 7'h4B | wk));
            irqchk(1'b0);
        end
        // limit with its high byte in use: bit 9 set
        lim = 32'h0000_0203;
        setup(lim, 7'h43);
        rdchk(`LDF_OFS_TO_HIGH, 32'h0000_0001);
        fault(1'b1, lim - 1, 7'h43, 1'b0, 0);
        fault(1'b1, lim, 7'h4B, 1'b1, 1);
        bus(1'b1, `LDF_OFS_CFG, cfg_exp(lim, 7'h4B));
        setup(lim, 7'h02);
        fault(1'b0, lim, 7'h06, 1'b0, 0);
        bus(1'b1, `LDF_OFS_CFG, cfg_exp(lim, 7'h03));
        irqchk(1'b1);
        bus(1'b1, `LDF_OFS_CTL, 32'h0000_0000);
        irqchk(1'b0);
        bus(1'b1, `LDF_OFS_CTL, 32'h0000_0001);
        setup(lim, 7'h07);
        fault(1'b1, lim, 7'h0B, 1'b1, 0);
        i_brk_state <= 1'b0;
        bus(1'b1, `LDF_OFS_CFG, cfg_exp(lim, 7'h0F));
        rdchk(`LDF_OFS_CFG, cfg_exp(lim, 7'h03));
        irqchk(1'b0);
        finish_test();
    end
    initial begin
        #3_000_000;
        errors++;
        finish_test();
    end
endmodule
